//--- bus_slave_model.sv
// bus slave and arbiter model facing the test vector master
// assumes one slave on the bus; retries a transfer once when asked
`timescale 1ns/1ps
module bus_slave_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        req_i,
  input  wire logic        lock_i,
  input  wire logic [1:0]  trans_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        write_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [1:0]  wait_i,
  input  wire logic        retry_i,
  output logic             grant_o,
  output logic             ready_o,
  output logic      [1:0]  resp_o,
  output logic      [31:0] rdata_o
);
  localparam logic [1:0] RTY = test_vector_pkg::RESP_RETRY;
  localparam logic [1:0] OK  = test_vector_pkg::RESP_OKAY;
  logic [31:0] mem [256];
  logic [31:0] pa;
  logic [7:0]  cyc;
  logic [2:0]  cnt;
  logic        ph, pw, rr, lr;
  wire         take = ready_o && trans_i == test_vector_pkg::TRANS_NONSEQ;
  wire         rq   = retry_i && !lr;
  // idle read bus shows a moving pattern, not stale data
  assign rdata_o = ph ? mem[pa[9:2]] : {4{cyc}};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      grant_o <= 1'b0;
      ready_o <= 1'b1;
      resp_o  <= OK;
      ph      <= 1'b0;
      cnt     <= 3'h0;
      lr      <= 1'b0;
      cyc     <= 8'h00;
    end else begin
      cyc     <= cyc + 8'h01;
      grant_o <= req_i || lock_i;
      if (ph && cnt != 3'h0) begin
        cnt     <= cnt - 3'h1;
        ready_o <= cnt == 3'h1;
        resp_o  <= (rr && cnt <= 3'h2) ? RTY : OK;
      end else if (ph) begin
        if (pw && !rr) mem[pa[9:2]] <= wdata_i;
        ph     <= 1'b0;
        resp_o <= OK;
        lr     <= rr;
      end
      if (take) begin
        ph      <= 1'b1;
        pa      <= addr_i;
        pw      <= write_i;
        rr      <= rq;
        cnt     <= {1'b0, wait_i} + {2'h0, rq};
        ready_o <= wait_i == 2'h0 && !rq;
        resp_o  <= (rq && wait_i == 2'h0) ? RTY : OK;
      end
    end
  end
endmodule : bus_slave_model

//--- pin_sync.sv
// two-stage synchroniser for pin inputs
// assumes inputs are asynchronous to clk_i; bits are not coherent as a word
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : pin_sync

//--- test_vector_master.sv
// test vector bus master: tester handshake pins in, system bus master out
// assumes tester pins asynchronous, one system clock, arbiter honours lock
// Contract
// - bursts always incrementing, unspecified length
// - size msb held low always
// - increment moves low eight address bits
// - increment off: same address repeated
// - increment disabled after reset
// - lock may cover one extra transfer
// - request bus, drive only once granted
// - ownership taken when ready high
// - split/retry re-arbitrate and repeat transfer
// - only idle, nonseq, seq types driven
// - write direction high for writes
// - acknowledge low until access done
// - request a enters test mode, then acknowledge
// - request pair gives next vector type
// - pair decode: 11 addr/ctrl, 10 wr, 01 rd, 00 exit
// - control vector bit map
// - invalid control vector leaves settings alone
// - turnarounds after reads; last of run is control
`timescale 1ns/1ps
module test_vector_master (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        vector_request_a_i,
  input  wire logic        vector_request_b_i,
  output logic             vector_acknowledge_o,
  input  wire logic [31:0] external_data_bus_i,
  output logic      [31:0] external_data_bus_o,
  output logic             external_data_bus_oe_o,
  output logic             bus_request_out_o,
  input  wire logic        bus_grant_in_i,
  input  wire logic        transfer_ready_in_i,
  input  wire logic [1:0]  transfer_response_in_i,
  input  wire logic [31:0] master_read_data_i,
  output logic      [31:0] master_address_out_o,
  output logic      [1:0]  transfer_type_out_o,
  output logic             write_direction_out_o,
  output logic      [2:0]  transfer_size_out_o,
  output logic      [2:0]  burst_type_out_o,
  output logic      [3:0]  protection_out_o,
  output logic             lock_request_out_o,
  output logic      [31:0] master_write_data_o
);
  typedef enum logic [2:0] {
    NORMAL, GRANT_WAIT, SETTLE, TEST, ADDR_PH, DATA_PH, EXIT
  } state_t;

  state_t                  state;
  test_vector_pkg::ctrl_t  ctrl;
  logic [1:0]              req_s;
  logic [1:0]              cur_type;
  logic [31:0]             vec_data;
  logic                    owned;
  logic                    run;
  logic [1:0]              ta_cnt;
  logic [1:0]              settle_cnt;

  pin_sync #(.WIDTH(2)) u_req_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({vector_request_a_i, vector_request_b_i}),
    .q_o     (req_s)
  );

  pin_sync #(.WIDTH(32)) u_data_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (external_data_bus_i),
    .q_o     (vec_data)
  );

  // decode of the vector now on the data bus
  wire is_ac     = (state == TEST) &&
                   (cur_type == test_vector_pkg::VEC_ADDR_CTRL);
  wire is_turn   = is_ac && (ta_cnt != 2'h0);
  wire next_ac   = (req_s == test_vector_pkg::VEC_ADDR_CTRL);
  wire is_addr   = is_ac && !is_turn && (next_ac || !run);
  wire is_ctrl   = is_ac && !is_turn && !next_ac && run;
  wire ctrl_ok   = is_ctrl && vec_data[test_vector_pkg::CV_VALID];
  wire is_write  = (state == TEST) &&
                   (cur_type == test_vector_pkg::VEC_WRITE);
  wire is_read   = (state == TEST) &&
                   (cur_type == test_vector_pkg::VEC_READ);
  wire is_exit   = (state == TEST) &&
                   (cur_type == test_vector_pkg::VEC_EXIT);
  wire addr_take = (state == ADDR_PH) && transfer_ready_in_i &&
                   (transfer_type_out_o == test_vector_pkg::TRANS_NONSEQ);
  wire data_end  = (state == DATA_PH) && transfer_ready_in_i;
  wire resp_rep  = (transfer_response_in_i == test_vector_pkg::RESP_RETRY) ||
                   (transfer_response_in_i == test_vector_pkg::RESP_SPLIT);
  wire done      = data_end && !resp_rep;
  wire [31:0] next_addr = test_vector_pkg::advance_addr(
                   master_address_out_o, ctrl.size);

  assign transfer_size_out_o = {1'b0, ctrl.size};
  assign protection_out_o    = ctrl.prot;
  assign burst_type_out_o    = test_vector_pkg::BURST_INCR;

  // bus ownership follows grant at the end of each transfer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      owned <= 1'b0;
    end else if (transfer_ready_in_i) begin
      owned <= bus_grant_in_i;
    end
  end

  // type register lines up with data after the two pin stages
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_type <= test_vector_pkg::VEC_EXIT;
    end else begin
      cur_type <= req_s;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= test_vector_pkg::CTRL_RESET;
    end else if (ctrl_ok) begin
      ctrl <= test_vector_pkg::decode_ctrl(vec_data);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run    <= 1'b0;
      ta_cnt <= 2'h0;
    end else begin
      if (is_ac && !is_turn) begin
        run <= next_ac;
      end
      if (done && !write_direction_out_o) begin
        ta_cnt <= test_vector_pkg::TURNAROUND_COUNT;
      end else if (is_turn) begin
        ta_cnt <= ta_cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_address_out_o <= 32'h0000_0000;
    end else if (is_addr) begin
      master_address_out_o <= vec_data;
    end else if (done && ctrl.inc) begin
      master_address_out_o <= next_addr;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      external_data_bus_o    <= 32'h0000_0000;
      external_data_bus_oe_o <= 1'b0;
    end else if (done && !write_direction_out_o) begin
      external_data_bus_o    <= master_read_data_i;
      external_data_bus_oe_o <= 1'b1;
    end else if (is_turn || is_write || state == EXIT) begin
      external_data_bus_oe_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_write_data_o   <= 32'h0000_0000;
      write_direction_out_o <= 1'b0;
    end else if (is_write || is_read) begin
      master_write_data_o   <= is_write ? vec_data : master_write_data_o;
      write_direction_out_o <= is_write;
    end
  end

  // lock follows the control record early, ahead of the address
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_request_out_o <= 1'b0;
    end else begin
      lock_request_out_o <= ctrl.lock && (state != NORMAL) &&
                            (state != EXIT);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state                <= NORMAL;
      settle_cnt           <= 2'h0;
      bus_request_out_o    <= 1'b0;
      vector_acknowledge_o <= 1'b0;
      transfer_type_out_o  <= test_vector_pkg::TRANS_IDLE;
    end else begin
      case (state)
        NORMAL: begin
          if (req_s[1]) begin
            bus_request_out_o <= 1'b1;
            state             <= GRANT_WAIT;
          end
        end
        GRANT_WAIT: begin
          if (owned) begin
            vector_acknowledge_o <= 1'b1;
            settle_cnt           <= test_vector_pkg::SETTLE_CYCLES;
            state                <= SETTLE;
          end
        end
        SETTLE: begin
          // pin stages still hold the vector from before the stall
          settle_cnt <= settle_cnt - 2'h1;
          if (settle_cnt == 2'h1) begin
            state <= TEST;
          end
        end
        TEST: begin
          if (is_write || is_read) begin
            vector_acknowledge_o <= 1'b0;
            state                <= ADDR_PH;
          end else if (is_exit) begin
            state <= EXIT;
          end
        end
        ADDR_PH: begin
          if (addr_take) begin
            transfer_type_out_o <= test_vector_pkg::TRANS_IDLE;
            state               <= DATA_PH;
          end else if (owned && transfer_ready_in_i) begin
            transfer_type_out_o <= test_vector_pkg::TRANS_NONSEQ;
          end
        end
        DATA_PH: begin
          if (data_end && resp_rep) begin
            state <= ADDR_PH;
          end else if (data_end) begin
            vector_acknowledge_o <= 1'b1;
            settle_cnt           <= test_vector_pkg::SETTLE_CYCLES;
            state                <= SETTLE;
          end
        end
        EXIT: begin
          bus_request_out_o    <= 1'b0;
          vector_acknowledge_o <= 1'b0;
          state                <= NORMAL;
        end
        default: begin
          state <= NORMAL;
        end
      endcase
    end
  end

  a_size_msb_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    transfer_size_out_o[2] == 1'b0) else $error("size msb set");
  a_no_busy_type: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    transfer_type_out_o != test_vector_pkg::TRANS_BUSY)
    else $error("busy type driven");
  a_burst_incr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    burst_type_out_o == test_vector_pkg::BURST_INCR)
    else $error("burst not incr");
  a_drive_granted: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    transfer_type_out_o == test_vector_pkg::TRANS_NONSEQ
    |-> bus_request_out_o && $past(owned)) else $error("drive w/o grant");
  a_ack_low_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == ADDR_PH || state == DATA_PH) |-> !vector_acknowledge_o)
    else $error("ack high mid access");
  a_fixed_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done && !ctrl.inc |=> $stable(master_address_out_o))
    else $error("address moved");
  a_inc_low_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done && ctrl.inc |=> master_address_out_o[31:8] ==
    $past(master_address_out_o[31:8]) && master_address_out_o[7:0] ==
    8'($past(master_address_out_o[7:0]) + (8'h01 << $past(ctrl.size))))
    else $error("bad increment");
  a_retry_repeat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    data_end && resp_rep |=> state == ADDR_PH && !vector_acknowledge_o
    ##1 !vector_acknowledge_o) else $error("retry not repeated");
  a_exit_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    is_exit |=> ##1 !bus_request_out_o && !vector_acknowledge_o &&
    !lock_request_out_o) else $error("exit left outputs");
  a_ctrl_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    is_ctrl && !vec_data[0] |=> $stable(ctrl))
    else $error("invalid control applied");
  a_write_dir: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    is_write |=> write_direction_out_o [*2]) else $error("write dir low");
endmodule : test_vector_master

//--- test_vector_master_test.sv
// self-checking bench: tester vector sequences against the bus master
// assumes bus_slave_model as the only slave and arbiter
`timescale 1ns/1ps
`define CHECK(n, e, s) begin compares++; if ((s) !== (e)) begin \
  err_count++; $display("FAIL %s exp %h got %h", n, e, s); end end
module test_vector_master_test;
  localparam logic [1:0] AC = test_vector_pkg::VEC_ADDR_CTRL;
  localparam logic [1:0] WR = test_vector_pkg::VEC_WRITE;
  localparam logic [1:0] RD = test_vector_pkg::VEC_READ;
  localparam int         D  = 2;
  logic        clk_i = 1'b0, rst_n_i, rty, ack, doe, req, gnt, rdy, wr, lock;
  logic        m_wr, m_lock, bad = 1'b0;
  logic [1:0]  ab, ws, rsp, trans;
  logic [2:0]  size, burst, m_size;
  logic [3:0]  prot, m_prot;
  logic [31:0] din, dout, rdata, addr, wdata, m_addr;
  logic [31:0] cv [3] = '{32'h441, 32'h225, 32'h69};
  logic [31:0] ia [3] = '{32'h1FC, 32'h1FE, 32'h1FF};
  logic [31:0] ic [3] = '{32'hE9, 32'h85, 32'h81};
  logic [2:0]  es [3] = '{3'h0, 3'h1, 3'h2};
  logic [3:0]  ep [3] = '{4'hA, 4'h5, 4'h3};
  int          err_count = 0, compares = 0, n_acc = 0, cycles = 0, n0, t;
  always #12.5 clk_i = ~clk_i;
  test_vector_master DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .vector_request_a_i(ab[1]), .vector_request_b_i(ab[0]),
    .vector_acknowledge_o(ack), .external_data_bus_i(din),
    .external_data_bus_o(dout), .external_data_bus_oe_o(doe),
    .bus_request_out_o(req), .bus_grant_in_i(gnt),
    .transfer_ready_in_i(rdy), .transfer_response_in_i(rsp),
    .master_read_data_i(rdata), .master_address_out_o(addr),
    .transfer_type_out_o(trans), .write_direction_out_o(wr),
    .transfer_size_out_o(size), .burst_type_out_o(burst),
    .protection_out_o(prot), .lock_request_out_o(lock),
    .master_write_data_o(wdata));
  bus_slave_model slave (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .lock_i(lock), .trans_i(trans), .addr_i(addr), .write_i(wr),
    .wdata_i(wdata), .wait_i(ws), .retry_i(rty), .grant_o(gnt),
    .ready_o(rdy), .resp_o(rsp), .rdata_o(rdata));
  // records each accepted address phase, flags illegal bus states
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
    if (trans === test_vector_pkg::TRANS_NONSEQ && rdy === 1'b1) begin
      m_addr <= addr;
      m_size <= size;
      m_prot <= prot;
      m_wr   <= wr;
      m_lock <= lock;
      n_acc  <= n_acc + 1;
    end
    if (rst_n_i === 1'b1 && (trans === test_vector_pkg::TRANS_BUSY ||
        burst !== test_vector_pkg::BURST_INCR || size[2] !== 1'b0 ||
        (trans !== test_vector_pkg::TRANS_IDLE && gnt !== 1'b1)))
      bad <= 1'b1;
  end
  task automatic tick();
    @(posedge clk_i);
    #D;
  endtask : tick
  // one vector cycle: pins give the type of the following data word
  task automatic vec(input logic [1:0] ty, input logic [31:0] d);
    tick();
    ab  = ty;
    din = d;
  endtask : vec
  // pins announce the type of the vector after this one while it is held
  task automatic xfer(input logic [31:0] d, input logic [1:0] nt = AC);
    vec(nt, d);
    t = 0;
    while (ack !== 1'b0 && t < 40) begin
      tick();
      t++;
    end
    `CHECK("ack_low", 1'b1, t < 40)
    while (ack !== 1'b1 && t < 90) begin
      tick();
      t++;
    end
    `CHECK("ack", 1'b1, ack)
  endtask : xfer
  // address run then control vector as the last of the run
  task automatic setup(input logic [31:0] a, c, input logic [1:0] ty);
    for (int i = 0; i < 6; i++) vec(AC, a);
    vec(ty, c);
  endtask : setup
  task automatic test_done();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  initial begin
    ab = 2'h0;
    din = 32'h0;
    ws = 2'h0;
    rty = 1'b0;
    rst_n_i = 1'b0;
    repeat (10) tick();
    rst_n_i = 1'b1;
    `CHECK("size", 3'h2, size)
    `CHECK("prot", 4'h3, prot)
    `CHECK("ack", 1'b0, ack)
    vec(AC, 32'h0);
    for (t = 0; t < 200 && ack !== 1'b1; t++) tick();
    `CHECK("req", 1'b1, req)
    `CHECK("ack", 1'b1, ack)
    setup(32'h1F0, 32'h90, WR);
    xfer(32'h1111_1111, WR);
    xfer(32'h2222_2222);
    `CHECK("addr", 32'h1F0, m_addr)
    `CHECK("size", 3'h2, m_size)
    `CHECK("lock", 1'b0, m_lock)
    `CHECK("wr", 1'b1, m_wr)
    setup(32'h1F0, 32'h69, RD);
    xfer(32'h0);
    `CHECK("rdata", 32'h2222_2222, dout)
    `CHECK("oe", 1'b1, doe)
    `CHECK("wr", 1'b0, m_wr)
    for (int i = 0; i < 3; i++) begin
      setup(32'h100, cv[i], WR);
      xfer(32'h3);
      `CHECK("size", es[i], m_size)
      `CHECK("prot", ep[i], m_prot)
    end
    for (int i = 0; i < 3; i++) begin
      setup(ia[i], ic[i], WR);
      xfer(32'h5, WR);
      xfer(32'h6);
      `CHECK("inc_addr", 32'h100, m_addr)
    end
    rty = 1'b1;
    ws = 2'h1;
    n0 = n_acc;
    setup(32'h40, 32'h69, WR);
    xfer(32'hA5A5_0F0F);
    `CHECK("repeats", n0 + 2, n_acc)
    rty = 1'b0;
    setup(32'h40, 32'h69, RD);
    xfer(32'h0);
    `CHECK("rdata", 32'hA5A5_0F0F, dout)
    setup(32'h44, 32'h79, WR);
    xfer(32'h7);
    `CHECK("lock", 1'b1, m_lock)
    `CHECK("gnt", 1'b1, gnt)
    vec(test_vector_pkg::VEC_EXIT, 32'h0);
    for (t = 0; t < 50 && (ack !== 1'b0 || req !== 1'b0); t++) tick();
    repeat (3) tick();
    `CHECK("ack", 1'b0, ack)
    `CHECK("req", 1'b0, req)
    `CHECK("lock", 1'b0, lock)
    `CHECK("bad", 1'b0, bad)
    test_done();
  end
endmodule : test_vector_master_test

//--- test_vector_pkg.sv
// constants, field layout and control record of the test vector bus master
// assumes a 32-bit system bus of the usual pipelined master/slave kind
package test_vector_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int SYNC_DEPTH = 2;

  // vector type seen on request pair a,b
  localparam logic [1:0] VEC_ADDR_CTRL = 2'h3;
  localparam logic [1:0] VEC_WRITE     = 2'h2;
  localparam logic [1:0] VEC_READ      = 2'h1;
  localparam logic [1:0] VEC_EXIT      = 2'h0;

  localparam logic [1:0] TRANS_IDLE   = 2'h0;
  localparam logic [1:0] TRANS_BUSY   = 2'h1;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TRANS_SEQ    = 2'h3;
  localparam logic [2:0] BURST_INCR   = 3'h1;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_ERROR   = 2'h1;
  localparam logic [1:0] RESP_RETRY   = 2'h2;
  localparam logic [1:0] RESP_SPLIT   = 2'h3;

  // control vector bit positions
  localparam int CV_VALID = 0;
  localparam int CV_SIZE0 = 2;
  localparam int CV_SIZE1 = 3;
  localparam int CV_LOCK  = 4;
  localparam int CV_PROT0 = 5;
  localparam int CV_PROT1 = 6;
  localparam int CV_INC   = 7;
  localparam int CV_PROT2 = 9;
  localparam int CV_PROT3 = 10;

  localparam logic [1:0] SIZE_RESET = 2'h2;
  localparam logic [3:0] PROT_RESET = 4'h3;
  localparam logic [1:0] TURNAROUND_COUNT = 2'h2;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  localparam int INC_BITS = 8;

  typedef struct packed {
    logic [1:0] size;
    logic [3:0] prot;
    logic       lock;
    logic       inc;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{size: SIZE_RESET, prot: PROT_RESET,
                                   lock: 1'b0, inc: 1'b0};

  function automatic ctrl_t decode_ctrl(input logic [DATA_W-1:0] v);
    ctrl_t c;
    c.size = {v[CV_SIZE1], v[CV_SIZE0]};
    c.prot = {v[CV_PROT3], v[CV_PROT2], v[CV_PROT1], v[CV_PROT0]};
    c.lock = v[CV_LOCK];
    c.inc  = v[CV_INC];
    return c;
  endfunction : decode_ctrl

  // only the low byte moves, wrapping inside its 256-byte window
  function automatic logic [ADDR_W-1:0] advance_addr(
      input logic [ADDR_W-1:0] a, input logic [1:0] size);
    logic [INC_BITS-1:0] step;
    step = 8'h01 << size;
    return {a[ADDR_W-1:INC_BITS], a[INC_BITS-1:0] + step};
  endfunction : advance_addr

endpackage : test_vector_pkg
